// [design/gpx_defs.vh]
// Register offsets, field values and reset values of the GPIO port
`ifndef GPX_DEFS_VH
`define GPX_DEFS_VH
`define GPX_OFF_LATCH     12'h000
`define GPX_OFF_DIR       12'h004
`define GPX_OFF_OPT       12'h008
`define GPX_OFF_SENSE     12'h00C
`define GPX_OFF_STATUS    12'h010
`define GPX_NPINS         8
`define GPX_RST_BYTE      8'h00
`define GPX_RST_SENSE     2'h0
`define GPX_SENS_FALL_LOW 2'h0
`define GPX_SENS_RISE     2'h1
`define GPX_SENS_FALL     2'h2
`define GPX_SENS_BOTH     2'h3
`define GPX_RESP_OKAY     2'h0
`define GPX_RESP_SLVERR   2'h2
`endif

// [design/gpx_port.v]
// Eight-pin GPIO port with alternate functions and NAND external interrupt
`timescale 1ns/100ps
`include "gpx_defs.vh"
//
// Contract
// - Eight independently configurable pins
// - Register bit X controls pin X
// - Input pins read back pin level
// - Latch writes leave input pins alone
// - Option bit selects input variant
// - Interrupt pins request external interrupt
// - Sensitivity held in separate control register
// - Enabled pins NANDed before detection
// - Request latch clears on vector fetch
// - Sensitivity write clears pending request
// - Output pins driven from latch, read latch
// - Option selects push-pull or open-drain
// - Alternate function overrides normal settings
// - Peripheral output forces output mode
// - Peripheral input pin stays readable
// - Direction bit: zero input, one output
// - Option zero floating, or open-drain
// - All registers reset to zero
// - Alternate output level read when input
module gpx_port (
  input  wire        clock_in,      // System clock, 20 MHz
  input  wire        sys_rst_in,    // Async reset, active high
  input  wire [11:0] s_axi_awaddr,  // Write address
  input  wire        s_axi_awvalid, // Write address valid
  output reg         s_axi_awready, // Write address ready
  input  wire [31:0] s_axi_wdata,   // Write data
  input  wire [3:0]  s_axi_wstrb,   // Write byte strobes
  input  wire        s_axi_wvalid,  // Write data valid
  output reg         s_axi_wready,  // Write data ready
  output reg  [1:0]  s_axi_bresp,   // Write response
  output reg         s_axi_bvalid,  // Write response valid
  input  wire        s_axi_bready,  // Write response ready
  input  wire [11:0] s_axi_araddr,  // Read address
  input  wire        s_axi_arvalid, // Read address valid
  output reg         s_axi_arready, // Read address ready
  output reg  [31:0] s_axi_rdata,   // Read data
  output reg  [1:0]  s_axi_rresp,   // Read response
  output reg         s_axi_rvalid,  // Read data valid
  input  wire        s_axi_rready,  // Read data ready
  input  wire [7:0]  pin_in,        // Pad levels
  output reg  [7:0]  pin_out,       // Pad drive value
  output reg  [7:0]  pin_oe_out,    // Pad drive enable, high drives
  output reg  [7:0]  pin_pullup_out,// Pull-up enable
  input  wire [7:0]  alt_en_in,     // Peripheral owns pin
  input  wire [7:0]  alt_out_en_in, // Peripheral drives pin
  input  wire [7:0]  alt_data_in,   // Peripheral output level
  input  wire [7:0]  alt_od_in,     // Peripheral wants open-drain
  output reg  [7:0]  alt_pin_out,   // Pin level to peripherals
  input  wire [7:0]  irq_group_in,  // Pins on this vector
  input  wire        vector_fetch_in, // Vector fetched pulse
  output reg         ext_irq_out    // External interrupt request
);
  //////////////////////////////////////////////////////////////////////////////
  // Register state
  // Software-visible bytes, the interrupt source history and the two
  // halves of a write that may arrive in separate cycles
  reg [7:0] latch_reg;
  reg [7:0] dir_reg;
  reg [7:0] opt_reg;
  reg [1:0] sense_reg;
  reg       pend_reg;
  reg       nand_prev_reg;
  reg       aw_hold_reg;
  reg       w_hold_reg;
  reg [11:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0]  wstrb_reg;
  wire [7:0] pin_sync;

  // Pin levels enter through two flops
  // Costs two cycles of latency on every read and interrupt path, but no
  // logic ever sees a pad level that may still be settling
  gpx_sync u_sync (
    .clock_in   (clock_in),
    .sys_rst_in (sys_rst_in),
    .async_in   (pin_in),
    .sync_out   (pin_sync)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Per-pin configuration decode
  reg [7:0] drive_en;
  reg [7:0] drive_val;
  reg [7:0] pull_en;
  reg [7:0] irq_en;
  reg [7:0] read_val;
  integer i;
  // A driving peripheral wins over direction, option and latch on the pads; the read value still follows direction
  // Open-drain high turns the driver off; the pin level then comes from the
  // board, so a missing external pull-up leaves it undefined.
  // A pin owned by a peripheral never joins the interrupt NAND, which
  // avoids spurious requests from the peripheral's own traffic.
  always @* begin
    drive_en  = 8'h00;
    drive_val = 8'h00;
    pull_en   = 8'h00;
    irq_en    = 8'h00;
    read_val  = 8'h00;
    for (i = 0; i < `GPX_NPINS; i = i + 1) begin
      if (alt_en_in[i] && alt_out_en_in[i]) begin
        drive_val[i] = alt_data_in[i];
        drive_en[i]  = alt_od_in[i] ? ~alt_data_in[i] : 1'b1;
        read_val[i]  = dir_reg[i] ? latch_reg[i] : alt_data_in[i];
      end else if (dir_reg[i]) begin
        drive_val[i] = latch_reg[i];
        drive_en[i]  = opt_reg[i] ? 1'b1 : ~latch_reg[i];
        read_val[i]  = latch_reg[i];
      end else begin
        read_val[i]  = pin_sync[i];
        pull_en[i]   = opt_reg[i];
        irq_en[i]    = opt_reg[i] & ~alt_en_in[i] & irq_group_in[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // External interrupt detection
  // NAND of enabled pins; disabled pins held high so they do not mask
  // Limitation: one low pin freezes the NAND high and hides every other
  // pin of the vector. Changing enables or direction can itself make an
  // edge here, so software should reconfigure before arming the vector.
  wire nand_src = ~&(pin_sync | ~irq_en);
  wire any_en   = |irq_en;
  reg  event_hit;
  always @* begin
    case (sense_reg)
      `GPX_SENS_FALL_LOW: event_hit = any_en & ~nand_src;
      `GPX_SENS_RISE:     event_hit = any_en & nand_src & ~nand_prev_reg;
      `GPX_SENS_FALL:     event_hit = any_en & ~nand_src & nand_prev_reg;
      `GPX_SENS_BOTH:     event_hit = any_en & (nand_src ^ nand_prev_reg);
      default:            event_hit = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path
  // Address and data land in holding registers in either order.
  // Each ready is a one-cycle pulse raised only after its valid is seen,
  // so a master that holds valid until ready always completes.
  // The register update and the response wait for the later half.
  // No new half is taken while a response is outstanding, which keeps
  // one write in flight at most and lets the holds clear safely.
  // Holding registers clear in the same edge that raises the response.
  // Only byte lane 0 carries register bits; upper lanes are ignored.
  // A write to an unmapped offset changes nothing and answers an error.

  // Known address check, used on both paths
  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `GPX_OFF_LATCH) || (a == `GPX_OFF_DIR) ||
               (a == `GPX_OFF_OPT) || (a == `GPX_OFF_SENSE) ||
               (a == `GPX_OFF_STATUS);
    end
  endfunction

  // Zero-extend a register byte to a bus word, used by several reads
  function [31:0] byte_word;
    input [7:0] b;
    begin
      byte_word = {24'h000000, b};
    end
  endfunction

  // Handshake: take address and data in either order, answer once both held
  always @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      aw_hold_reg   <= 1'b0;
      w_hold_reg    <= 1'b0;
      awaddr_reg    <= 12'h000;
      wdata_reg     <= 32'h00000000;
      wstrb_reg     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `GPX_RESP_OKAY;
    end else begin
      // Ready pulses once per offered half, never while that half is held
      s_axi_awready <= s_axi_awvalid & ~aw_hold_reg & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready  <= s_axi_wvalid & ~w_hold_reg & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_reg  <= s_axi_awaddr;
        aw_hold_reg <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
        w_hold_reg <= 1'b1;
      end
      if (aw_hold_reg && w_hold_reg && !s_axi_bvalid) begin
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awaddr_reg) ? `GPX_RESP_OKAY : `GPX_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register writes happen when the held pair completes
  // The latch byte is stored whatever the direction, so the level is
  // already right when a pin turns into an output. Writes without
  // byte lane 0 change nothing but still get an answer.
  wire commit = aw_hold_reg & w_hold_reg & ~s_axi_bvalid & wstrb_reg[0];
  wire sense_commit = commit && (awaddr_reg == `GPX_OFF_SENSE);
  always @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      latch_reg <= `GPX_RST_BYTE;
      dir_reg   <= `GPX_RST_BYTE;
      opt_reg   <= `GPX_RST_BYTE;
      sense_reg <= `GPX_RST_SENSE;
    end else if (commit) begin
      case (awaddr_reg)
        `GPX_OFF_LATCH: latch_reg <= wdata_reg[7:0];
        `GPX_OFF_DIR:   dir_reg   <= wdata_reg[7:0];
        `GPX_OFF_OPT:   opt_reg   <= wdata_reg[7:0];
        `GPX_OFF_SENSE: sense_reg <= wdata_reg[1:0];
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pending request latch; a new event wins over a vector fetch
  // A sensitivity write is the software cancel path, so it beats a
  // coincident event. In level mode the latch sets again on every cycle
  // the condition holds, so a fetch only sticks once the source is gone.
  // The latch has no register address; software sees it only through
  // the request line.
  always @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pend_reg      <= 1'b0;
      nand_prev_reg <= 1'b0;
      ext_irq_out   <= 1'b0;
    end else begin
      nand_prev_reg <= nand_src;
      if (event_hit && !sense_commit)
        pend_reg <= 1'b1;
      else if (vector_fetch_in || sense_commit)
        pend_reg <= 1'b0;
      ext_irq_out <= (event_hit && !sense_commit) |
                     (pend_reg & ~vector_fetch_in & ~sense_commit);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path, one cycle after address taken
  // Ready pulses only after valid is seen, so read data is captured while
  // the address still stands; unmapped offsets answer an error and zero.
  // Status shows the raw NAND source and pins, never the pending latch.
  always @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `GPX_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= mapped(s_axi_araddr) ? `GPX_RESP_OKAY : `GPX_RESP_SLVERR;
        case (s_axi_araddr)
          `GPX_OFF_LATCH:  s_axi_rdata <= byte_word(read_val);
          `GPX_OFF_DIR:    s_axi_rdata <= byte_word(dir_reg);
          `GPX_OFF_OPT:    s_axi_rdata <= byte_word(opt_reg);
          `GPX_OFF_SENSE:  s_axi_rdata <= {30'h0, sense_reg};
          `GPX_OFF_STATUS: s_axi_rdata <= {23'h0, nand_src, pin_sync};
          default:         s_axi_rdata <= 32'h00000000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registered pad and peripheral outputs
  // Every pad control lags its register by one cycle; traded for outputs
  // that come straight from flops with no decode glitches on the pads
  always @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pin_out        <= 8'h00;
      pin_oe_out     <= 8'h00;
      pin_pullup_out <= 8'h00;
      alt_pin_out    <= 8'h00;
    end else begin
      pin_out        <= drive_val;
      pin_oe_out     <= drive_en;
      pin_pullup_out <= pull_en;
      // Output-mode pins not driven by a peripheral give peripherals the latch value
      alt_pin_out    <= (dir_reg & ~alt_out_en_in & latch_reg) |
                        (~(dir_reg & ~alt_out_en_in) & pin_sync);
    end
  end
endmodule // gpx_port

// [design/gpx_sync.v]
// Two-flop synchroniser for the pin levels
`timescale 1ns/100ps
`include "gpx_defs.vh"
module gpx_sync (
  input  wire       clock_in,   // System clock
  input  wire       sys_rst_in, // Async reset, active high
  input  wire [7:0] async_in,   // Raw pin levels
  output reg  [7:0] sync_out    // Synchronised levels
);
  reg [7:0] meta_reg;
  // First stage feeds only the second
  always @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta_reg <= 8'h00;
      sync_out <= 8'h00;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule // gpx_sync

// [sim/gpx_board.sv]
// Board-side pad model resolving each pin level
`timescale 1ns/100ps
module gpx_board (
  input  wire logic       clock_in,       // System clock
  input  wire logic [7:0] pin_out,        // Port drive value
  input  wire logic [7:0] pin_oe_out,     // Port drive enable
  input  wire logic [7:0] pin_pullup_out, // Port pull-up
  input  wire logic [7:0] ext_val_in,     // Board drive value
  input  wire logic [7:0] ext_en_in,      // Board drives pin
  output wire logic [7:0] pin_lvl_out     // Resolved level
);
  reg [7:0] wobble_reg = 8'h55; // Floating pins wander, never hold a value
  always @(posedge clock_in) begin
    wobble_reg <= ~wobble_reg;
  end
  // Port wins, then board, then pull-up; open-drain high floats
  assign pin_lvl_out = (pin_oe_out & pin_out) | (~pin_oe_out & ext_en_in & ext_val_in)
    | (~pin_oe_out & ~ext_en_in & (pin_pullup_out | wobble_reg));
endmodule // gpx_board

// [sim/gpx_port_props.sv]
// Port-level assertions for the GPIO port
`timescale 1ns/100ps
module gpx_port_props (
  input wire logic        clock_in, sys_rst_in, ext_irq_out,
  input wire logic        s_axi_bvalid, s_axi_bready, s_axi_rvalid, s_axi_rready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [7:0]  pin_in, pin_out, pin_oe_out, pin_pullup_out, alt_pin_out,
  input wire logic [7:0]  alt_en_in, alt_out_en_in, alt_data_in, alt_od_in
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  wire [7:0] drv = alt_en_in & alt_out_en_in; // Pins a peripheral drives
  // Peripheral controls held, away from reset
  sequence s_alt_steady;
    !$past(sys_rst_in) && $stable({alt_en_in, alt_out_en_in, alt_data_in, alt_od_in});
  endsequence
  // Pads quiet, so the two-flop path has settled
  sequence s_pads_quiet;
    $stable(pin_in) && $stable(pin_pullup_out);
  endsequence
  AST_ALT_OE: assert property (
    s_alt_steady [*2] |-> (pin_oe_out & drv) == (drv & ~(alt_od_in & alt_data_in)))
    else $error("peripheral drive enable wrong");
  AST_ALT_DATA: assert property (
    s_alt_steady [*2] |-> (pin_out & drv & pin_oe_out) == (alt_data_in & drv & pin_oe_out))
    else $error("peripheral drive level wrong");
  AST_RST_PADS: assert property (
    disable iff (1'b0) sys_rst_in |-> (pin_oe_out | pin_pullup_out) == 8'h00)
    else $error("pads active in reset");
  AST_RST_BUS: assert property (
    disable iff (1'b0) sys_rst_in |-> !(s_axi_bvalid || s_axi_rvalid || ext_irq_out))
    else $error("request or answer in reset");
  AST_PULL_EXCL: assert property (
    (pin_pullup_out & pin_oe_out) == 8'h00) else $error("pull-up on a driven pin");
  AST_SYNC_READ: assert property (
    s_pads_quiet [*4] |-> ((alt_pin_out ^ pin_in) & pin_pullup_out) == 8'h00)
    else $error("input level not passed on");
  AST_B_HOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  AST_R_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
endmodule // gpx_port_props
bind gpx_port gpx_port_props gpx_port_props_inst (.*);

// [sim/testbench.sv]
// Self-checking bench for the GPIO port
`timescale 1ns/100ps
`include "gpx_defs.vh"
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("unexpected at %0t: got %0h want %0h", $time, got, exp); end end
module testbench;
  logic clock_in = 1'b0, sys_rst_in = 1'b0, vector_fetch_in = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h00000000, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] r;
  logic [7:0] alt_en_in = 8'h00, alt_out_en_in = 8'h00, alt_data_in = 8'h00, alt_od_in = 8'h00;
  logic [7:0] irq_group_in = 8'h00, ext_val = 8'h5A, ext_en = 8'hFF;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ext_irq_out;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] pin_in, pin_out, pin_oe_out, pin_pullup_out, alt_pin_out;
  int miscompares = 0, num_checks = 0;
  gpx_port gpx_port_inst (.*);
  gpx_board gpx_board_inst (.clock_in(clock_in), .pin_out(pin_out), .pin_oe_out(pin_oe_out),
    .pin_pullup_out(pin_pullup_out), .ext_val_in(ext_val), .ext_en_in(ext_en), .pin_lvl_out(pin_in));
  ////////////////////////////////////////
  initial forever #25 clock_in = ~clock_in;
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [7:0] v, output logic [1:0] rs);
    @(posedge clock_in);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock_in);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] dv, output logic [1:0] rs);
    @(posedge clock_in);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock_in);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    dv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Watchdog, far beyond the few hundred cycles needed
  initial begin
    #400000;
    miscompares++;
    complete_run();
  end
  ////////////////////////////////////////
  initial begin
    sys_rst_in <= 1'b1; // Raised after time 0 so the async reset sees an edge
    cyc(10);
    sys_rst_in <= 1'b0;
    cyc(6);
    `CHK(pin_oe_out | pin_pullup_out, 8'h00)
    for (int i = 1; i < 4; i++) begin
      rd(12'(4 * i), d, r);
      `CHK(d, 32'h00000000)
    end
    wr(`GPX_OFF_LATCH, 8'hA5, r);
    `CHK(r, `GPX_RESP_OKAY)
    rd(`GPX_OFF_LATCH, d, r);
    `CHK(d[7:0], 8'h5A)
    `CHK(pin_oe_out, 8'h00)
    wr(`GPX_OFF_OPT, 8'hFF, r);
    cyc(2);
    `CHK(pin_pullup_out, 8'hFF)
    ext_en <= 8'h00;
    wr(`GPX_OFF_DIR, 8'hFF, r);
    cyc(2);
    `CHK(pin_oe_out, 8'hFF)
    `CHK(pin_out, 8'hA5)
    `CHK(pin_pullup_out, 8'h00)
    rd(`GPX_OFF_LATCH, d, r);
    `CHK(d[7:0], 8'hA5)
    wr(`GPX_OFF_OPT, 8'h00, r);
    cyc(2);
    `CHK(pin_oe_out, 8'h5A)
    `CHK(pin_out & pin_oe_out, 8'h00)
    alt_en_in <= 8'h0F;
    alt_out_en_in <= 8'h0F;
    alt_data_in <= 8'h03;
    cyc(3);
    `CHK(pin_out[3:0], 4'h3)
    wr(`GPX_OFF_DIR, 8'h00, r);
    ext_en <= 8'hF0;
    ext_val <= 8'hA0;
    cyc(4);
    `CHK(pin_oe_out, 8'h0F)
    rd(`GPX_OFF_LATCH, d, r);
    `CHK(d[7:0], 8'hA3)
    `CHK(alt_pin_out, 8'hA3)
    alt_od_in <= 8'h03;
    cyc(3);
    `CHK(pin_oe_out, 8'h0C)
    rd(12'h020, d, r);
    `CHK({r, d}, {`GPX_RESP_SLVERR, 32'h00000000})
    wr(12'h020, 8'hFF, r);
    `CHK(r, `GPX_RESP_SLVERR)
    // Pin 0 alone on the vector, pulled up, each sensitivity code
    alt_en_in <= 8'h00;
    ext_en <= 8'hFF;
    irq_group_in <= 8'h01;
    wr(`GPX_OFF_OPT, 8'hFF, r);
    for (int s = 0; s < 4; s++) begin
      ext_val <= 8'hFF;
      cyc(8);
      wr(`GPX_OFF_SENSE, 8'(s), r);
      ext_val <= 8'hFE;
      cyc(8);
      `CHK(ext_irq_out, s != 2)
      vector_fetch_in <= 1'b1;
      @(posedge clock_in);
      vector_fetch_in <= 1'b0;
      cyc(4);
      `CHK(ext_irq_out, 1'b0)
      ext_val <= 8'hFF;
      cyc(8);
      `CHK(ext_irq_out, s != 1)
    end
    // Low pin 0 hides edges on pin 1; a sensitivity write cancels
    irq_group_in <= 8'h03;
    ext_val <= 8'hFE;
    cyc(8);
    wr(`GPX_OFF_SENSE, 8'h03, r);
    cyc(2);
    `CHK(ext_irq_out, 1'b0)
    ext_val <= 8'hFC;
    cyc(8);
    ext_val <= 8'hFE;
    cyc(8);
    `CHK(ext_irq_out, 1'b0)
    complete_run();
  end
endmodule // testbench
